// >>> hdl/eba_ctrl.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Byte storage, 512/1K/2K, byte reads and writes
// - Byte read stalls CPU four cycles
// - Write launch stalls CPU two cycles
// - Strobe within four cycles starts write
// - Expired arm means no write
// - No write start while flash programs
// - Busy bit cleared by hardware at end
// - Busy blocks reads and address changes
// - Write lasts 27072 oscillator cycles
// - Write completes through power-down, clock kept
// - Write completes across CPU reset
// - Address, data, control in I/O space
// - Read strobe loads data register immediately
// - Arm self-clears after four cycles
// - Ready interrupt while enabled and idle
// - Linear addressing, width from capacity
module eba_ctrl #(
   parameter int STORE_BYTES = eba_pkg::STORE_BYTES,
   parameter int WRITE_OSC_CYCLES = eba_pkg::WRITE_OSC_CYCLES,
   parameter int OSC_TICK_DIV = eba_pkg::OSC_TICK_DIV
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_por_n,
   input wire eba_pkg::eba_bus_t i_bus,
   output logic [7:0] o_rdata,
   input wire logic i_self_program_active,
   input wire logic i_global_irq_en,
   input wire logic i_power_down,
   output logic o_cpu_stall,
   output logic o_ready_irq,
   output logic o_clk_keepalive
);
   import eba_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Sizes

   localparam int ADDR_W = $clog2(STORE_BYTES);
   localparam int CNT_W = $clog2(WRITE_OSC_CYCLES + 1);
   localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_OSC_CYCLES);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [15:0] ADDR_MASK = 16'(STORE_BYTES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0] store_mem [STORE_BYTES];

   logic [7:0] addr_lo_ff;
   logic [7:0] addr_hi_ff;
   logic [7:0] nxt_addr_lo;
   logic [7:0] nxt_addr_hi;
   logic [7:0] data_ff;
   logic [7:0] nxt_data;
   logic rie_ff;
   logic nxt_rie;
   logic [2:0] arm_cnt_ff;
   logic [2:0] nxt_arm_cnt;
   logic [2:0] stall_cnt_ff;
   logic [2:0] nxt_stall_cnt;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   eba_eng_t eng_ff;
   eba_eng_t nxt_eng;
   logic [CNT_W-1:0] prog_cnt_ff;
   logic [CNT_W-1:0] nxt_prog_cnt;
   logic [ADDR_W-1:0] prog_addr_ff;
   logic [7:0] prog_data_ff;

   logic [15:0] addr_cat;
   logic [ADDR_W-1:0] addr_sel;
   logic hit_ctrl;
   logic hit_data;
   logic hit_adrl;
   logic hit_adrh;
   logic wr_ctrl;
   logic busy;
   logic write_arm;
   logic arm_req;
   logic strobe_req;
   logic read_req;
   logic start_write;
   logic do_read;
   logic osc_tick;
   logic prog_done;
   logic [7:0] ctrl_view;
   logic [7:0] read_mux;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode

   assign hit_ctrl = (i_bus.addr == OFS_CTRL);
   assign hit_data = (i_bus.addr == OFS_DATA);
   assign hit_adrl = (i_bus.addr == OFS_ADRL);
   assign hit_adrh = (i_bus.addr == OFS_ADRH);
   assign wr_ctrl = i_bus.wr && hit_ctrl;

   ////////////////////////////////////////////////////////////////////////////////
   // Arming, launch and read requests

   assign busy = (eng_ff == ENG_PROG);
   assign write_arm = (arm_cnt_ff != 3'h0);
   assign arm_req = wr_ctrl && i_bus.wdata[BIT_WRITE_ARM];
   assign strobe_req = wr_ctrl && i_bus.wdata[BIT_WRITE_STROBE_BUSY];
   assign read_req = wr_ctrl && i_bus.wdata[BIT_READ_STROBE];

   // Strobe without a live arm does nothing
   assign start_write = strobe_req && write_arm && !busy
      && !i_self_program_active;

   // Reads are blocked while the array is being programmed
   assign do_read = read_req && !busy && !start_write;

   // Window counts down from the arming write; a launch on its last count still
   // lands, one cycle later it is gone
   always_comb begin
      nxt_arm_cnt = arm_cnt_ff;
      if (start_write) begin
         nxt_arm_cnt = 3'h0;
      end else if (arm_req) begin
         nxt_arm_cnt = ARM_WINDOW_CYC;
      end else if (write_arm) begin
         nxt_arm_cnt = arm_cnt_ff - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // CPU stall

   always_comb begin
      nxt_stall_cnt = (stall_cnt_ff != 3'h0) ? stall_cnt_ff - 3'h1 : 3'h0;
      if (do_read) begin
         nxt_stall_cnt = READ_STALL_CYC;
      end else if (start_write) begin
         nxt_stall_cnt = WRITE_STALL_CYC;
      end
   end

   assign o_cpu_stall = (stall_cnt_ff != 3'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // Address, data and enable registers

   assign addr_cat = {addr_hi_ff, addr_lo_ff} & ADDR_MASK;
   assign addr_sel = addr_cat[ADDR_W-1:0];

   always_comb begin
      nxt_addr_lo = addr_lo_ff;
      nxt_addr_hi = addr_hi_ff;
      if (i_bus.wr && hit_adrl && !busy) begin
         nxt_addr_lo = i_bus.wdata;
      end
      if (i_bus.wr && hit_adrh && !busy) begin
         nxt_addr_hi = i_bus.wdata & ADDR_MASK[15:8];
      end
   end

   always_comb begin
      nxt_data = data_ff;
      if (do_read) begin
         nxt_data = store_mem[addr_sel];
      end else if (i_bus.wr && hit_data) begin
         nxt_data = i_bus.wdata;
      end
   end

   assign nxt_rie = wr_ctrl ? i_bus.wdata[BIT_READY_IRQ_ENABLE] : rie_ff;

   // CPU-facing state follows the CPU reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_lo_ff <= RST_BYTE;
         addr_hi_ff <= RST_BYTE;
         data_ff <= RST_BYTE;
         rie_ff <= RST_RIE;
         arm_cnt_ff <= 3'h0;
         stall_cnt_ff <= 3'h0;
         rdata_ff <= RST_BYTE;
      end else begin
         addr_lo_ff <= nxt_addr_lo;
         addr_hi_ff <= nxt_addr_hi;
         data_ff <= nxt_data;
         rie_ff <= nxt_rie;
         arm_cnt_ff <= nxt_arm_cnt;
         stall_cnt_ff <= nxt_stall_cnt;
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write engine

   eba_osc_tick #(
      .DIV(OSC_TICK_DIV)
   ) u_osc_tick (
      .i_clk(i_clk),
      .i_por_n(i_por_n),
      .i_run(busy),
      .o_tick(osc_tick)
   );

   assign prog_done = busy && osc_tick && (prog_cnt_ff == CNT_ONE);

   always_comb begin
      nxt_eng = eng_ff;
      nxt_prog_cnt = prog_cnt_ff;
      case (eng_ff)
         ENG_IDLE: begin
            if (start_write) begin
               nxt_eng = ENG_PROG;
               nxt_prog_cnt = WRITE_LOAD;
            end
         end
         ENG_PROG: begin
            if (prog_done) begin
               nxt_eng = ENG_IDLE;
               nxt_prog_cnt = '0;
            end else if (osc_tick) begin
               nxt_prog_cnt = prog_cnt_ff - CNT_ONE;
            end
         end
         default: begin
            nxt_eng = ENG_IDLE;
            nxt_prog_cnt = '0;
         end
      endcase
   end

   // Engine sits on the power-on reset only, so a CPU reset mid-write does
   // not abort it; a brownout still does
   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         eng_ff <= ENG_IDLE;
         prog_cnt_ff <= '0;
         prog_addr_ff <= '0;
         prog_data_ff <= RST_BYTE;
      end else begin
         eng_ff <= nxt_eng;
         prog_cnt_ff <= nxt_prog_cnt;
         if (start_write) begin
            prog_addr_ff <= addr_sel;
            prog_data_ff <= data_ff;
         end
      end
   end

   // Byte array; committed at the end of the timed write
   always_ff @(posedge i_clk) begin
      if (prog_done) begin
         store_mem[prog_addr_ff] <= prog_data_ff;
      end
   end

   // Clock request ignores power-down until the write is over
   assign o_clk_keepalive = busy || (i_power_down && busy);

   ////////////////////////////////////////////////////////////////////////////////
   // Read path and interrupt

   assign ctrl_view = {4'h0, rie_ff, write_arm, busy, 1'b0};

   always_comb begin
      read_mux = 8'h00;
      if (hit_ctrl) begin
         read_mux = ctrl_view;
      end else if (hit_data) begin
         read_mux = data_ff;
      end else if (hit_adrl) begin
         read_mux = addr_lo_ff;
      end else if (hit_adrh) begin
         read_mux = addr_hi_ff;
      end
   end

   assign nxt_rdata = i_bus.rd ? read_mux : rdata_ff;
   assign o_rdata = rdata_ff;

   // Level, not a pulse: stays up for as long as the engine is idle with rie_ff and i_global_irq_en set
   assign o_ready_irq = rie_ff && i_global_irq_en && !busy;

endmodule // eba_ctrl

// >>> hdl/eba_pkg.sv
package eba_pkg;

   // Register offsets in the I/O space
   localparam logic [7:0] OFS_CTRL = 8'h1F;
   localparam logic [7:0] OFS_DATA = 8'h20;
   localparam logic [7:0] OFS_ADRL = 8'h21;
   localparam logic [7:0] OFS_ADRH = 8'h22;

   // Control register bit positions
   localparam int BIT_READ_STROBE = 0;
   localparam int BIT_WRITE_STROBE_BUSY = 1;
   localparam int BIT_WRITE_ARM = 2;
   localparam int BIT_READY_IRQ_ENABLE = 3;

   // Values after reset
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_RIE = 1'b0;

   // CPU stall lengths and arming window, in clock cycles
   localparam logic [2:0] READ_STALL_CYC = 3'h4;
   localparam logic [2:0] WRITE_STALL_CYC = 3'h2;
   localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;

   // Write timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int WRITE_TIME_NS = 3300000;
   localparam int WRITE_OSC_CYCLES = 27072;
   localparam int OSC_TICK_DIV = WRITE_TIME_NS / (CLK_PERIOD_NS * WRITE_OSC_CYCLES);

   // Storage size of the smallest variant
   localparam int STORE_BYTES = 512;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } eba_bus_t;

   // Write engine states
   typedef enum logic [1:0] {
      ENG_IDLE = 2'b01,
      ENG_PROG = 2'b10
   } eba_eng_t;

endpackage

// >>> hdl/eba_osc_tick.sv
`timescale 1ns/1ps

module eba_osc_tick #(
   parameter int DIV = eba_pkg::OSC_TICK_DIV
) (
   input wire logic i_clk,
   input wire logic i_por_n,
   input wire logic i_run,
   output logic o_tick
);
   import eba_pkg::*;

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic wrap;

   // Stands in for the calibrated oscillator, derived from the one clock
   assign wrap = (cnt_ff == LAST);
   assign nxt_cnt = (!i_run || wrap) ? '0 : cnt_ff + 1'b1;
   assign o_tick = i_run && wrap;

   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule // eba_osc_tick

// >>> testbench/eba_ctrl_asserts.sv
`timescale 1ns/1ps
module eba_ctrl_asserts
   import eba_pkg::*;
#(
   parameter int STORE_BYTES = 512,
   parameter int WRITE_OSC_CYCLES = 27072,
   parameter int OSC_TICK_DIV = 15
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_por_n,
   input wire eba_pkg::eba_bus_t i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic i_self_program_active,
   input wire logic i_global_irq_en,
   input wire logic i_power_down,
   input wire logic o_cpu_stall,
   input wire logic o_ready_irq,
   input wire logic o_clk_keepalive
);
   import eba_pkg::*;
   localparam int BUSY_LEN = WRITE_OSC_CYCLES * OSC_TICK_DIV;
   logic ctl_wr, start_req, rd_req;
   logic [31:0] busy_cnt_ff, nxt_busy_cnt;
   logic [3:0] arm_age_ff, nxt_arm_age;
   assign ctl_wr = i_bus.wr && (i_bus.addr == OFS_CTRL);
   assign start_req = ctl_wr && i_bus.wdata[BIT_WRITE_STROBE_BUSY] && !i_self_program_active;
   assign rd_req = ctl_wr && i_bus.wdata[BIT_READ_STROBE] && !i_bus.wdata[BIT_WRITE_STROBE_BUSY];
   assign nxt_busy_cnt = o_clk_keepalive ? busy_cnt_ff + 32'h1 : 32'h0;
   assign nxt_arm_age = (ctl_wr && i_bus.wdata[BIT_WRITE_ARM]) ? 4'h1 : arm_age_ff + 4'h1;
   // Busy length survives CPU reset, so only power-on reset clears it
   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         busy_cnt_ff <= 32'h0;
      end else begin
         busy_cnt_ff <= nxt_busy_cnt;
      end
   end
   // Saturates so a stale arm never looks fresh
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         arm_age_ff <= 4'hF;
      end else if (nxt_arm_age != 4'h0) begin
         arm_age_ff <= nxt_arm_age;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n || !i_por_n);
   a_start_window: assert property (
      $rose(o_clk_keepalive) |-> arm_age_ff inside {[4'h2:4'h5]})
      else $error("write start outside arm window");
   a_start_cause: assert property (
      $rose(o_clk_keepalive) |-> $past(start_req))
      else $error("write start without strobe");
   a_write_stall: assert property (
      $rose(o_clk_keepalive) |-> o_cpu_stall [*2] ##1 !o_cpu_stall)
      else $error("write stall length wrong");
   a_read_stall: assert property (
      rd_req && !o_clk_keepalive |=> o_cpu_stall [*4] ##1 !o_cpu_stall)
      else $error("read stall length wrong");
   a_read_refused: assert property (
      rd_req && o_clk_keepalive && !o_cpu_stall |=> !o_cpu_stall)
      else $error("read taken while busy");
   a_rdata_holds: assert property (
      !i_bus.rd |=> $stable(o_rdata))
      else $error("read data moved without read");
   a_busy_len: assert property (disable iff (!i_por_n)
      $fell(o_clk_keepalive) |-> busy_cnt_ff >= BUSY_LEN - 1 && busy_cnt_ff <= BUSY_LEN + 1)
      else $error("write time wrong");
   a_busy_bound: assert property (disable iff (!i_por_n)
      busy_cnt_ff <= BUSY_LEN + 1)
      else $error("write never ends");
   a_irq_idle: assert property (
      o_ready_irq |-> i_global_irq_en && !o_clk_keepalive)
      else $error("ready irq while busy or masked");
   c_write: cover property ($rose(o_clk_keepalive));
   c_read: cover property (rd_req && !o_clk_keepalive);
   c_irq: cover property ($rose(o_ready_irq));
endmodule // eba_ctrl_asserts

bind eba_ctrl eba_ctrl_asserts #(.STORE_BYTES(STORE_BYTES),
   .WRITE_OSC_CYCLES(WRITE_OSC_CYCLES), .OSC_TICK_DIV(OSC_TICK_DIV)) i_eba_ctrl_asserts (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_bus(i_bus), .o_rdata(o_rdata),
   .i_self_program_active(i_self_program_active), .i_global_irq_en(i_global_irq_en),
   .i_power_down(i_power_down), .o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq),
   .o_clk_keepalive(o_clk_keepalive));

// >>> testbench/eba_cpu.sv
`timescale 1ns/1ps
module eba_cpu
   import eba_pkg::*;
(
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output eba_pkg::eba_bus_t o_bus
);
   import eba_pkg::*;
   initial o_bus = '0;
   // Released bus shows inverted values, never the last ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk);
      o_bus <= '{~a, ~d, 1'b0, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_clk);
      o_bus <= '{~a, 8'hFF, 1'b0, 1'b0};
      @(posedge i_clk);
      d = i_rdata;
   endtask
   // Arm alone, then strobe after gap; both writes set the ready-irq enable bit to rie
   task automatic launch(input logic rie, input int gap);
      wr(OFS_CTRL, {4'h0, rie, 3'b100});
      repeat (gap) @(posedge i_clk);
      wr(OFS_CTRL, {4'h0, rie, 3'b010});
   endtask
   // Bounded poll of busy bit
   task automatic wait_idle();
      logic [7:0] v;
      for (int n = 0; n < 40; n++) begin
         rd(OFS_CTRL, v);
         if (v[BIT_WRITE_STROBE_BUSY] === 1'b0) break;
      end
   endtask
endmodule // eba_cpu

// >>> testbench/eba_ctrl_tb.sv
`timescale 1ns/1ps
module eba_ctrl_tb;
   import eba_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic spa = 1'b0;
   logic gie = 1'b1;
   logic pdn = 1'b0;
   eba_bus_t bus;
   logic [7:0] rdata, v, dv, last;
   logic stall, irq, keep;
   logic [8:0] a;
   logic [31:0] lf = 32'hE39685BA;
   int err_count = 0;
   int checks = 0;
   always #4 clk = ~clk;
   // Short write time keeps the run brief
   eba_ctrl #(.WRITE_OSC_CYCLES(8), .OSC_TICK_DIV(2)) i_eba_ctrl (.i_clk(clk), .i_rst_n(rst_n),
      .i_por_n(por_n), .i_bus(bus), .o_rdata(rdata), .i_self_program_active(spa),
      .i_global_irq_en(gie), .i_power_down(pdn), .o_cpu_stall(stall), .o_ready_irq(irq),
      .o_clk_keepalive(keep));
   eba_cpu i_eba_cpu (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         $display("FAIL %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic conclude();
      if (err_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic w(input logic [7:0] ad, input logic [7:0] d);
      i_eba_cpu.wr(ad, d);
   endtask
   task automatic rb(input logic [8:0] ad, input logic [7:0] e);
      w(OFS_ADRL, ad[7:0]);
      w(OFS_ADRH, {7'h0, ad[8]});
      w(OFS_CTRL, 8'h01);
      @(posedge clk);
      chk("rd_stall", 8'h01, {7'h0, stall});
      i_eba_cpu.rd(OFS_DATA, v);
      chk("readback", e, v);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      i_eba_cpu.rd(OFS_CTRL, v);
      chk("ctrl_rst", RST_BYTE, v);
      i_eba_cpu.rd(8'h5A, v);
      chk("unmapped", 8'h00, v);
      w(OFS_ADRH, 8'hFF);
      i_eba_cpu.rd(OFS_ADRH, v);
      chk("adrh_mask", 8'h01, v);
      for (int k = 0; k < 4; k++) begin
         lf = nxt(lf);
         a = (k == 0) ? 9'h000 : (k == 1) ? 9'h1FF : lf[8:0];
         dv = lf[23:16];
         w(OFS_DATA, dv);
         w(OFS_ADRL, a[7:0]);
         w(OFS_ADRH, {7'h0, a[8]});
         pdn <= k[0];
         i_eba_cpu.launch(1'b0, k % 3);
         @(posedge clk);
         chk("busy", 8'h01, {7'h0, keep});
         chk("wr_stall", 8'h01, {7'h0, stall});
         w(OFS_ADRL, ~a[7:0]);
         w(OFS_CTRL, 8'h01);
         i_eba_cpu.rd(OFS_ADRL, v);
         chk("adr_locked", a[7:0], v);
         chk("rd_refused", 8'h00, {7'h0, stall});
         i_eba_cpu.rd(OFS_DATA, v);
         chk("data_kept", dv, v);
         // CPU reset in mid-write must not abort it
         if (k == 3) begin
            rst_n <= 1'b0;
            @(posedge clk);
            rst_n <= 1'b1;
         end
         i_eba_cpu.wait_idle();
         chk("idle", 8'h00, {7'h0, keep});
         pdn <= 1'b0;
         rb(a, dv);
         last = dv;
      end
      for (int c = 0; c < 3; c++) begin
         lf = nxt(lf);
         w(OFS_DATA, lf[7:0]);
         spa <= (c == 2);
         if (c == 0) begin
            w(OFS_CTRL, 8'h04);
            i_eba_cpu.rd(OFS_CTRL, v);
            chk("arm_set", 8'h04, v);
            w(OFS_CTRL, 8'h02);
         end else if (c == 1) begin
            w(OFS_CTRL, 8'h02);
         end else begin
            i_eba_cpu.launch(1'b0, 0);
         end
         repeat (3) @(posedge clk);
         chk("no_write", 8'h00, {7'h0, keep});
         spa <= 1'b0;
         rb(a, last);
      end
      w(OFS_CTRL, 8'h08);
      @(posedge clk);
      chk("irq_on", 8'h01, {7'h0, irq});
      gie <= 1'b0;
      @(posedge clk);
      chk("irq_gie", 8'h00, {7'h0, irq});
      gie <= 1'b1;
      i_eba_cpu.launch(1'b1, 1);
      @(posedge clk);
      chk("irq_busy", 8'h00, {7'h0, irq});
      i_eba_cpu.wait_idle();
      chk("irq_idle", 8'h01, {7'h0, irq});
      conclude();
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule // eba_ctrl_tb
